/* File: design/scr_command_bank.sv */
// Serial command decoder and control register bank
`timescale 1ns/100ps
`default_nettype none

module scr_command_bank
  import scr_pkg::*;
(
  input wire logic ref_clk_i, // System clock, 200 MHz
  input wire logic reset_i, // Asynchronous reset, active high
  input wire logic sclk_i, // Serial clock from host
  input wire logic sync_n_i, // Frame sync from host, active low
  input wire logic sdi_i, // Serial data in
  output logic sdo_o, // Serial data out
  output logic [10:0] dac_readback_select_o, // Readback select register
  output logic [10:0] conversion_sequence_o, // Conversion sequence register
  output logic [10:0] general_control_o, // General control register
  output logic [10:0] analog_input_pin_mask_o, // Analog input pin mask
  output logic [10:0] analog_output_pin_mask_o, // Analog output pin mask
  output logic [10:0] pulldown_pin_mask_o, // Pull-down enable mask
  output logic [10:0] readback_and_load_mode_o, // Readback/load mode register
  output logic [10:0] digital_output_pin_mask_o, // Digital output pin mask
  output logic [10:0] digital_output_levels_o, // Digital output levels
  output logic [10:0] digital_input_pin_mask_o, // Digital input pin mask
  output logic [10:0] power_and_reference_control_o, // Power and reference control
  output logic [10:0] output_drive_style_o, // Open-drain select per pin
  output logic [10:0] high_impedance_pin_mask_o, // Three-state pin mask
  output logic dac_wr_valid_o, // One-cycle pulse: DAC write
  output logic [14:0] dac_wr_o, // DAC write channel and data
  output logic software_reset_command_busy_o // Software reset in progress
);

  // Link domain: shift in on falling sclk, count bits, toggle per word
  typedef struct packed {
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] word;
    logic tog;
    logic [WORD_W-1:0] out_sh;
  } scr_link_s;

  scr_link_s lk_q, lk_d;
  logic [BIT_CNT_W-1:0] lk_cnt_q;
  logic [WORD_W-1:0] rb_word_q;

  always_comb
  begin
    lk_d = lk_q;
    if (!sync_n_i)
    begin
      lk_d.shift = {lk_q.shift[WORD_W-2:0], sdi_i};
      lk_d.out_sh = {lk_q.out_sh[WORD_W-2:0], 1'b0};
      if (lk_cnt_q == '1)
      begin
        lk_d.word = {lk_q.shift[WORD_W-2:0], sdi_i};
        lk_d.tog = ~lk_q.tog;
      end
      if (lk_cnt_q == '0)
      begin
        // Reload readback word at frame start
        // Word settles long before the first fall, as sclk is parked between frames
        lk_d.out_sh = {rb_word_q[WORD_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(negedge sclk_i or posedge reset_i)
  begin
    if (reset_i)
      lk_q <= '0;
    else
      lk_q <= lk_d;
  end

  // Sync high ends a frame even with sclk parked, so a cut frame cannot skew the next
  always_ff @(negedge sclk_i or posedge reset_i or posedge sync_n_i)
  begin
    if (reset_i || sync_n_i)
      lk_cnt_q <= '0;
    else
      lk_cnt_q <= lk_cnt_q + 4'h1;
  end

  logic sdo_link_q;
  always_ff @(posedge sclk_i or posedge reset_i)
  begin
    if (reset_i)
      sdo_link_q <= 1'b0;
    else
      sdo_link_q <= (lk_cnt_q == '0) ? rb_word_q[WORD_W-1] : lk_q.out_sh[WORD_W-1];
  end

  // System domain state
  typedef struct packed {
    scr_reg_t [NUM_REGS-1:0] regs;
    logic [2:0] tog_sync;
    logic [WORD_W-1:0] word;
    logic dac_valid;
    logic [14:0] dac_wr;
    scr_state_e state;
    logic [SWRST_CNT_W-1:0] rst_cnt;
    logic sdo;
  } scr_sys_s;

  scr_sys_s s_q, s_d;
  logic [WORD_W-1:0] word_sync1_q;

  function automatic scr_reg_t reg_default(input logic [3:0] addr);
    reg_default = (addr == ADDR_PULLDOWN_PIN_MASK) ? RST_PULLDOWN : RST_DEFAULT;
  endfunction

  function automatic logic is_storage(input logic [3:0] addr);
    is_storage = (addr != ADDR_NO_OPERATION) && (addr != ADDR_UNLISTED)
               && (addr != ADDR_SOFTWARE_RESET_COMMAND);
  endfunction

  logic new_word;
  logic [3:0] waddr;
  scr_reg_t rbl;
  assign new_word = s_q.tog_sync[2] ^ s_q.tog_sync[1];
  assign waddr = s_q.word[CMD_ADDR_HI:CMD_ADDR_LO];
  assign rbl = s_q.regs[ADDR_READBACK_AND_LOAD_MODE];

  always_comb
  begin
    s_d = s_q;
    s_d.tog_sync = {s_q.tog_sync[1:0], lk_q.tog};
    s_d.dac_valid = 1'b0;
    s_d.sdo = sdo_link_q;
    if (new_word)
      s_d.word = word_sync1_q;
    case (s_q.state)
      ST_IDLE:
      begin
        if (new_word && word_sync1_q[CMD_DAC_BIT])
        begin
          s_d.dac_valid = 1'b1;
          s_d.dac_wr = {word_sync1_q[CMD_CH_HI:CMD_CH_LO], word_sync1_q[DATA_W-1:0]};
        end
        else if (new_word)
          s_d.state = ST_HOLD;
      end
      ST_HOLD:
      begin
        s_d.state = ST_IDLE;
        if (waddr == ADDR_SOFTWARE_RESET_COMMAND)
        begin
          s_d.state = ST_RESET;
          s_d.rst_cnt = '0;
        end
        else if (is_storage(waddr))
          s_d.regs[waddr] = s_q.word[CMD_PAY_HI:0];
      end
      ST_RESET:
      begin
        // Restore defaults, hold busy for the reset time
        for (int i = 0; i < NUM_REGS; i++)
          s_d.regs[i] = reg_default(4'(i));
        s_d.rst_cnt = s_q.rst_cnt + 16'h0001;
        if (s_q.rst_cnt == 16'(SWRST_CYCLES - 1))
          s_d.state = ST_IDLE;
      end
      default:
        s_d.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s_q.regs <= '0;
      s_q.regs[ADDR_PULLDOWN_PIN_MASK] <= RST_PULLDOWN;
      s_q.tog_sync <= '0;
      s_q.word <= '0;
      s_q.dac_valid <= 1'b0;
      s_q.dac_wr <= '0;
      s_q.state <= ST_IDLE;
      s_q.rst_cnt <= '0;
      s_q.sdo <= 1'b0;
      word_sync1_q <= '0;
      rb_word_q <= '0;
    end
    else
    begin
      s_q <= s_d;
      // Word is stable for a whole frame once the toggle arrives
      word_sync1_q <= lk_q.word;
      // Select register for next transfer when readback enabled
      rb_word_q <= rbl[RBL_EN_BIT] ?
        {5'h00, s_q.regs[rbl[RBL_SEL_HI:RBL_SEL_LO]]} : '0;
    end
  end

  // Readback fields stored as written, decoded downstream
  assign sdo_o = s_q.sdo;
  assign dac_readback_select_o = s_q.regs[ADDR_DAC_READBACK_SELECT];
  assign conversion_sequence_o = s_q.regs[ADDR_CONVERSION_SEQUENCE];
  assign general_control_o = s_q.regs[ADDR_GENERAL_CONTROL];
  assign analog_input_pin_mask_o = s_q.regs[ADDR_ANALOG_INPUT_PIN_MASK];
  assign analog_output_pin_mask_o = s_q.regs[ADDR_ANALOG_OUTPUT_PIN_MASK];
  assign pulldown_pin_mask_o = s_q.regs[ADDR_PULLDOWN_PIN_MASK];
  assign readback_and_load_mode_o = s_q.regs[ADDR_READBACK_AND_LOAD_MODE];
  assign digital_output_pin_mask_o = s_q.regs[ADDR_DIGITAL_OUTPUT_PIN_MASK];
  assign digital_output_levels_o = s_q.regs[ADDR_DIGITAL_OUTPUT_LEVELS];
  assign digital_input_pin_mask_o = s_q.regs[ADDR_DIGITAL_INPUT_PIN_MASK];
  assign power_and_reference_control_o = s_q.regs[ADDR_POWER_AND_REFERENCE_CONTROL];
  assign output_drive_style_o = s_q.regs[ADDR_OUTPUT_DRIVE_STYLE];
  assign high_impedance_pin_mask_o = s_q.regs[ADDR_HIGH_IMPEDANCE_PIN_MASK];
  assign dac_wr_valid_o = s_q.dac_valid;
  assign dac_wr_o = s_q.dac_wr;
  assign software_reset_command_busy_o = (s_q.state == ST_RESET);

endmodule // scr_command_bank
`default_nettype wire

/* File: design/scr_pkg.sv */
// Package: command layout, register map and timing for the serial command register bank
package scr_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned PAY_W = 11;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned CH_W = 3;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned NUM_REGS = 16;
  localparam int unsigned BIT_CNT_W = 4;

  // Command word fields
  localparam int unsigned CMD_DAC_BIT = 15;
  localparam int unsigned CMD_ADDR_HI = 14;
  localparam int unsigned CMD_ADDR_LO = 11;
  localparam int unsigned CMD_CH_HI = 14;
  localparam int unsigned CMD_CH_LO = 12;
  localparam int unsigned CMD_PAY_HI = 10;

  // Register addresses
  localparam logic [3:0] ADDR_NO_OPERATION = 4'h0;
  localparam logic [3:0] ADDR_DAC_READBACK_SELECT = 4'h1;
  localparam logic [3:0] ADDR_CONVERSION_SEQUENCE = 4'h2;
  localparam logic [3:0] ADDR_GENERAL_CONTROL = 4'h3;
  localparam logic [3:0] ADDR_ANALOG_INPUT_PIN_MASK = 4'h4;
  localparam logic [3:0] ADDR_ANALOG_OUTPUT_PIN_MASK = 4'h5;
  localparam logic [3:0] ADDR_PULLDOWN_PIN_MASK = 4'h6;
  localparam logic [3:0] ADDR_READBACK_AND_LOAD_MODE = 4'h7;
  localparam logic [3:0] ADDR_DIGITAL_OUTPUT_PIN_MASK = 4'h8;
  localparam logic [3:0] ADDR_DIGITAL_OUTPUT_LEVELS = 4'h9;
  localparam logic [3:0] ADDR_DIGITAL_INPUT_PIN_MASK = 4'ha;
  localparam logic [3:0] ADDR_POWER_AND_REFERENCE_CONTROL = 4'hb;
  localparam logic [3:0] ADDR_OUTPUT_DRIVE_STYLE = 4'hc;
  localparam logic [3:0] ADDR_HIGH_IMPEDANCE_PIN_MASK = 4'hd;
  localparam logic [3:0] ADDR_UNLISTED = 4'he;
  localparam logic [3:0] ADDR_SOFTWARE_RESET_COMMAND = 4'hf;

  // Reset values
  localparam logic [10:0] RST_DEFAULT = 11'h000;
  localparam logic [10:0] RST_PULLDOWN = 11'h0ff;

  // Readback-select field positions
  localparam int unsigned DRB_EN_HI = 4;
  localparam int unsigned DRB_EN_LO = 3;
  localparam int unsigned DRB_CH_HI = 2;
  localparam int unsigned DRB_CH_LO = 0;
  localparam logic [1:0] DRB_EN_ON = 2'h1;

  // Readback/load mode field positions
  localparam int unsigned RBL_EN_BIT = 6;
  localparam int unsigned RBL_SEL_HI = 5;
  localparam int unsigned RBL_SEL_LO = 2;
  localparam int unsigned RBL_LOAD_CONVERTER_STROBE_HI = 1;
  localparam int unsigned RBL_LOAD_CONVERTER_STROBE_LO = 0;

  // Software reset duration
  localparam int unsigned SWRST_TIME_NS = 250000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SWRST_CYCLES = SWRST_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SWRST_CNT_W = 16;

  typedef logic [PAY_W-1:0] scr_reg_t;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } scr_dac_wr_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RESET = 3'b010,
    ST_HOLD = 3'b100
  } scr_state_e;

endpackage

/* File: sim/scr_command_bank_checker.sv */
// Assertions on the command bank outputs
`timescale 1ns/100ps
`default_nettype none
module scr_command_bank_checker
  import scr_pkg::*;
(
  input wire logic ref_clk_i, // System clock
  input wire logic reset_i, // Async reset
  input wire logic [10:0] dac_readback_select_o, // Readback select
  input wire logic [10:0] general_control_o, // General control
  input wire logic [10:0] pulldown_pin_mask_o, // Pull-down mask
  input wire logic dac_wr_valid_o, // DAC write pulse
  input wire logic [14:0] dac_wr_o, // DAC write payload
  input wire logic software_reset_command_busy_o // Software reset busy
);
  localparam int busy_min = SWRST_CYCLES - 1;
  localparam int busy_max = SWRST_CYCLES + 1;
  logic [16:0] busy_cnt_q;
  logic [16:0] busy_cnt_d;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  always_comb busy_cnt_d = software_reset_command_busy_o ? busy_cnt_q + 17'h1 : 17'h0;
  always_ff @(posedge ref_clk_i or posedge reset_i)
    if (reset_i)
      busy_cnt_q <= 17'h0;
    else
      busy_cnt_q <= busy_cnt_d;
  sequence s_busy_run;
    software_reset_command_busy_o ##1 software_reset_command_busy_o;
  endsequence
  chk_pulldown_rst: assert property ($fell(reset_i) |-> pulldown_pin_mask_o == 11'h0ff)
    else $error("pull-down mask not all set after reset");
  chk_regs_rst: assert property ($fell(reset_i) |->
    general_control_o == 11'h000 && dac_readback_select_o == 11'h000)
    else $error("register not cleared after reset");
  chk_dac_pulse: assert property (dac_wr_valid_o |=> !dac_wr_valid_o)
    else $error("DAC write strobe longer than one cycle");
  chk_dac_hold: assert property (dac_wr_valid_o |=> $stable(dac_wr_o)[*8])
    else $error("DAC write payload moved without a write");
  chk_busy_quiet: assert property (software_reset_command_busy_o |-> !dac_wr_valid_o)
    else $error("DAC write accepted during software reset");
  chk_busy_defaults: assert property (s_busy_run |=>
    pulldown_pin_mask_o == 11'h0ff && general_control_o == 11'h000)
    else $error("registers not at defaults during software reset");
  chk_busy_span: assert property ($fell(software_reset_command_busy_o) |->
    busy_cnt_q >= busy_min && busy_cnt_q <= busy_max)
    else $error("software reset length wrong");
  chk_busy_bound: assert property (busy_cnt_q <= busy_max)
    else $error("software reset overran its time");
endmodule // scr_command_bank_checker
bind scr_command_bank scr_command_bank_checker i_scr_command_bank_checker (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .dac_readback_select_o(dac_readback_select_o),
  .general_control_o(general_control_o), .pulldown_pin_mask_o(pulldown_pin_mask_o),
  .dac_wr_valid_o(dac_wr_valid_o), .dac_wr_o(dac_wr_o), .software_reset_command_busy_o(software_reset_command_busy_o));
`default_nettype wire

/* File: sim/scr_host_model.sv */
// Host model: serial master that frames 16-bit words
`timescale 1ns/100ps
`default_nettype none
module scr_host_model (
  output logic sclk_o, // Serial clock, idles high
  output logic sync_n_o, // Frame sync, active low
  output logic sdi_o, // Data to device
  input wire logic sdo_i // Data from device
);
  initial
  begin
    sclk_o = 1'b1;
    sync_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Framed MSB first; callers keep the top bit clear on control writes
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = '0;
    #1.3 sync_n_o = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi_o = w[15-i];
      #40 sclk_o = 1'b0;
      r = {r[14:0], sdo_i};
      #40 sclk_o = 1'b1;
    end
    #40 sync_n_o = 1'b1;
    // Released line must not echo the last bit
    sdi_o = ~sdi_o;
    #200;
  endtask
endmodule // scr_host_model
`default_nettype wire

/* File: sim/tb_scr_command_bank.sv */
// Self-checking bench for the command register bank
`timescale 1ns/100ps
`default_nettype none
module tb_scr_command_bank;
  import scr_pkg::*;
  logic ref_clk_i, reset_i, sclk, sync_n, sdi, sdo, dac_wr_valid, busy;
  logic [14:0] dac_wr;
  logic [10:0] rg [1:13];
  logic [15:0] r, w;
  int failures = 0, samples_checked = 0, pulses = 0, p;
  scr_command_bank i_scr_command_bank (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .sclk_i(sclk), .sync_n_i(sync_n), .sdi_i(sdi), .sdo_o(sdo),
    .dac_readback_select_o(rg[1]), .conversion_sequence_o(rg[2]), .general_control_o(rg[3]),
    .analog_input_pin_mask_o(rg[4]), .analog_output_pin_mask_o(rg[5]),
    .pulldown_pin_mask_o(rg[6]), .readback_and_load_mode_o(rg[7]),
    .digital_output_pin_mask_o(rg[8]), .digital_output_levels_o(rg[9]),
    .digital_input_pin_mask_o(rg[10]), .power_and_reference_control_o(rg[11]),
    .output_drive_style_o(rg[12]), .high_impedance_pin_mask_o(rg[13]),
    .dac_wr_valid_o(dac_wr_valid), .dac_wr_o(dac_wr), .software_reset_command_busy_o(busy));
  scr_host_model i_scr_host_model (.sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi), .sdo_i(sdo));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
    if (dac_wr_valid === 1'b1)
      pulses++;
  function automatic logic [10:0] pat(input logic [3:0] a);
    // Reserved bits of the readback select stay zero
    return (a == 4'h1) ? {7'h0, a} : {a[2:0] ^ 3'h5, a, ~a};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    i_scr_host_model.xfer({1'b0, a, d}, 16, r);
  endtask
  task automatic chk_defaults(input string n);
    for (int a = 1; a < 14; a++)
      chk(n, (a == 6) ? 16'h00ff : 16'h0000, 16'(rg[a]));
  endtask
  task automatic chk_pat(input string n);
    for (int a = 1; a < 14; a++)
      chk(n, 16'(pat(4'(a))), 16'(rg[a]));
  endtask
  task automatic report_and_stop;
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    failures++;
    report_and_stop();
  end
  initial
  begin
    reset_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    reset_i = 1'b0;
    chk_defaults("reset");
    for (int a = 1; a < 14; a++)
      wr(4'(a), pat(4'(a)));
    chk_pat("write");
    wr(4'h0, 11'h7ff);
    wr(4'he, 11'h7ff);
    chk_pat("ignored");
    for (int c = 0; c < 8; c++)
    begin
      wr(4'h1, {6'h0, 2'h1, 3'(c)});
      chk("rdsel", {10'h0, 3'h1, 3'(c)}, 16'(rg[1]));
      p = pulses;
      w = {1'b1, 3'(c), 12'ha5c ^ 12'(c)};
      i_scr_host_model.xfer(w, 16, r);
      chk("dacwr", {1'b0, w[14:0]}, {1'b0, dac_wr});
      chk("pulse", 16'(p + 1), 16'(pulses));
    end
    wr(4'h7, 11'h058);
    i_scr_host_model.xfer(16'h0000, 16, r);
    chk("readback", 16'(pat(4'h6)), r);
    i_scr_host_model.xfer({1'b0, 4'h3, 11'h123}, 8, r);
    chk("partial", 16'(pat(4'h3)), 16'(rg[3]));
    wr(4'hf, 11'h000);
    chk("busy", 16'h0001, {15'h0, busy});
    wr(4'h3, 11'h555);
    for (int i = 0; i < 60000 && busy !== 1'b0; i++)
      @(posedge ref_clk_i);
    chk("busy_end", 16'h0000, {15'h0, busy});
    chk_defaults("swreset");
    wr(4'h3, 11'h2aa);
    chk("after_reset", 16'h02aa, 16'(rg[3]));
    report_and_stop();
  end
endmodule // tb_scr_command_bank
`default_nettype wire
